/* rtl/line_printer_interface.sv */
`timescale 1ns/1ps
module line_printer_interface
    import lp_pkg::*;
#(
    parameter logic [15:0] CSR_ADDR = CSR_ADDR_DEFAULT,
    parameter logic [15:0] VECTOR   = VECTOR_DEFAULT
) (
    input  wire logic            clock,
    input  wire logic            reset_n,
    input  wire logic            bus_initialise_low,
    input  wire logic [15:0]     bus_addr,
    input  wire logic            bus_read,
    input  wire logic            bus_write,
    input  wire logic [15:0]     bus_wdata,
    input  wire logic            bus_iack,
    output logic      [15:0]     bus_rdata,
    output logic                 bus_irq,
    input  wire printer_status_t printer_in,
    output printer_out_t         printer_out
);
    printer_status_t ps;
    logic            init_s;
    logic            pending_q;
    logic            err_q;
    logic            done_q;
    logic            ie_q;
    logic            type2_q;
    logic            init_prev_q;
    logic [7:0]      char_q;
    logic            strobe_w;

    // The init pin is inverted ahead of the synchroniser so that its reset value is the idle level.
    // Otherwise a false init edge would follow every reset.
    lp_sync #(.WIDTH(6)) u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in ({printer_in, !bus_initialise_low}),
        .sync_out ({ps, init_s})
    );

    wire init_active = init_s;
    wire init_edge   = init_active && !init_prev_q;
    wire csr_hit     = (bus_addr == CSR_ADDR);
    wire buf_hit     = (bus_addr == CSR_ADDR + BUF_OFFSET);
    wire csr_wr      = bus_write && csr_hit;
    wire buf_wr      = bus_write && buf_hit;
    wire csr_rd      = bus_read && csr_hit;
    wire type2       = !ps.select_n;
    wire err_clear   = ie_q ? ((bus_iack && done_q) || (csr_rd && !done_q)) : 1'b1;
    wire err_d       = ps.fault || (err_q && !err_clear);
    wire done_set    = ps.demand && (!type2 || ps.online) && !pending_q;

    // Done and error update together; the error flag (fault or held error) wins, then init, then the write clear.
    // A demand that is still high from the last character cannot undo a write, because
    // pending stays set until the printer drops demand for the character just written.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err_q       <= ERR_RESET;
            done_q      <= DONE_RESET;
            ie_q        <= IE_RESET;
            type2_q     <= 1'b0;
            init_prev_q <= 1'b0;
            pending_q   <= 1'b0;
        end else begin
            err_q       <= err_d;
            init_prev_q <= init_active;
            type2_q     <= type2;
            if (err_d) begin
                done_q <= 1'b0;
            end else if (init_edge) begin
                done_q <= 1'b1;
            end else if (buf_wr) begin
                done_q <= 1'b0;
            end else if (done_set) begin
                done_q <= 1'b1;
            end
            if (buf_wr) begin
                pending_q <= 1'b1;
            end else if (!ps.demand) begin
                pending_q <= 1'b0;
            end
            if (init_active) begin
                ie_q <= 1'b0;
            end else if (csr_wr) begin
                ie_q <= bus_wdata[IE_BIT];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            char_q <= 8'h00;
        end else if (buf_wr) begin
            char_q <= bus_wdata[7:0];
        end
    end

    lp_strobe u_strobe (
        .clock   (clock),
        .reset_n (reset_n),
        .start   (buf_wr),
        .strobe  (strobe_w)
    );

    wire [15:0] csr_view = {err_q, 7'h00, done_q, ie_q, 4'h0,
                            type2_q && ps.online, type2_q && ps.busy};

    // Buffer reads return zero by leaving that address out of the mux.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= 16'h0000;
        end else if (bus_iack) begin
            bus_rdata <= VECTOR;
        end else if (csr_rd) begin
            bus_rdata <= csr_view;
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    assign bus_irq     = ie_q && (err_q || done_q);
    assign printer_out = '{strobe: strobe_w, extra_data_bit: char_q[7], data: char_q[6:0]};
endmodule

/* rtl/lp_pkg.sv */
// Function
// - Error flag follows any printer fault.
// - Without interrupt enable, error clears when fault ends.
// - With enable, clear on vector read or not-ready status read; vector read only clears with done set, which error prevents.
// - Done sets when printer online and requesting; online checked for second type only.
// - Bus initialise sets done, no interrupt as enable clears.
// - Character write clears done.
// - Error set holds done cleared.
// - Interrupt enable read/write, cleared by initialise.
// - Interrupt request when enabled and done or error.
// - Bit 1 shows online for second type.
// - Bit 0 shows busy for second type.
// - Buffer high byte reads zero, writes discarded.
// - Buffer bit 7 drives extra data bit, reads zero.
// - Low seven bits carry character, read zero.
// - Buffer decoded at status address plus two.
// - Vector returned during interrupt acknowledge, default 200.
// - Grounded select line chooses second printer type.
package lp_pkg;
    localparam logic [15:0] CSR_ADDR_DEFAULT = 16'hFF4C;
    localparam logic [15:0] BUF_OFFSET       = 16'h0002;
    localparam logic [15:0] VECTOR_DEFAULT   = 16'h0080;
    localparam int          ERR_BIT          = 15;
    localparam int          DONE_BIT         = 7;
    localparam int          IE_BIT           = 6;
    localparam int          ONLINE_BIT       = 1;
    localparam int          BUSY_BIT         = 0;
    localparam logic        DONE_RESET       = 1'b1;
    localparam logic        IE_RESET         = 1'b0;
    localparam logic        ERR_RESET        = 1'b0;
    localparam int          STROBE_CYCLES    = 4;

    typedef struct packed {
        logic       fault;
        logic       demand;
        logic       online;
        logic       busy;
        logic       select_n;
    } printer_status_t;

    typedef struct packed {
        logic       strobe;
        logic       extra_data_bit;
        logic [6:0] data;
    } printer_out_t;
endpackage

/* rtl/lp_sync.sv */
`timescale 1ns/1ps
module lp_sync
    import lp_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* rtl/lp_strobe.sv */
`timescale 1ns/1ps
module lp_strobe
    import lp_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic start,
    output logic      strobe
);
    logic [2:0] count_q;

    // The pulse is stretched so slow printer inputs see it reliably.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 3'h0;
        end else if (start) begin
            count_q <= 3'(STROBE_CYCLES);
        end else if (count_q != 3'h0) begin
            count_q <= count_q - 3'h1;
        end
    end

    assign strobe = (count_q != 3'h0);
endmodule

/* dv/line_printer_interface_checker.sv */
`timescale 1ns/1ps
module line_printer_interface_checker
    import lp_pkg::*;
#(
    parameter logic [15:0] CSR_ADDR = CSR_ADDR_DEFAULT,
    parameter logic [15:0] VECTOR = VECTOR_DEFAULT
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic bus_initialise_low,
    input wire logic [15:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_iack,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_irq,
    input wire printer_status_t printer_in,
    input wire printer_out_t printer_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence csr_rd; bus_read && bus_addr == CSR_ADDR; endsequence
    sequence buf_wr; bus_write && bus_addr == CSR_ADDR + 16'h0002; endsequence
    AST_IDLE: assert property (!(bus_read || bus_iack) |=> bus_rdata == 16'h0000)
        else $error("read data not idle");
    AST_VECTOR: assert property (bus_iack |=> bus_rdata == VECTOR)
        else $error("wrong vector");
    AST_BUF_READ: assert property (bus_read && bus_addr == CSR_ADDR + 16'h0002 |=> !bus_rdata)
        else $error("buffer read not zero");
    AST_STROBE: assert property (buf_wr |=> printer_out.strobe [*4] ##1 !printer_out.strobe)
        else $error("strobe length wrong");
    AST_DATA: assert property (buf_wr |=> printer_out[7:0] == $past(bus_wdata[7:0]))
        else $error("printer data wrong");
    AST_ERR: assert property (printer_in.fault [*4] ##0 csr_rd |=> bus_rdata[15] && !bus_rdata[7])
        else $error("error flag wrong");
    AST_TYPE1: assert property (printer_in.select_n [*4] ##0 csr_rd |=> !bus_rdata[1:0])
        else $error("type bits not zero");
    AST_IE_INIT: assert property (!bus_initialise_low [*4] |-> !bus_irq)
        else $error("request during init");
endmodule
bind line_printer_interface line_printer_interface_checker #(.CSR_ADDR(CSR_ADDR), .VECTOR(VECTOR)) chk (.*);

/* dv/printer_model.sv */
`timescale 1ns/1ps
module printer_model
    import lp_pkg::*;
(
    input  wire logic         clock,
    input  wire printer_out_t printer_out,
    input  wire logic         fault,
    input  wire logic         second_type,
    output printer_status_t   printer_in
);
    int wait_q = 0;
    // Demand drops with the strobe and returns slowly, like a printer busy on a line.
    always @(posedge clock) wait_q <= printer_out.strobe ? 12 : wait_q - (wait_q != 0);
    assign printer_in = '{fault, !printer_out.strobe && wait_q == 0, second_type && !fault,
                          second_type && wait_q != 0, !second_type};
endmodule

/* dv/line_printer_interface_test.sv */
`timescale 1ns/1ps
module line_printer_interface_test
    import lp_pkg::*;
;
    logic clock = 0, reset_n = 0, bus_initialise_low = 1, bus_read = 0, bus_write = 0, bus_iack = 0;
    logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000, bus_rdata, w, r, cs = CSR_ADDR_DEFAULT;
    logic bus_irq, fault = 0, st = 0;
    printer_status_t printer_in;
    printer_out_t printer_out;
    int mismatches = 0, checked = 0, ie = 0;
    always #5 clock = ~clock;
    line_printer_interface uut (.*);
    printer_model peer (.clock(clock), .printer_out(printer_out), .fault(fault), .second_type(st),
                        .printer_in(printer_in));
    task automatic conclude();
        if (mismatches == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic compare(input logic [15:0] got, exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] csr(input int e, d, o, b);
        return {e[0], 7'h00, d[0], ie[0], 4'h0, o[0], b[0]};
    endfunction
    task automatic access(input logic [2:0] kind, input logic [15:0] a, d);
        @(negedge clock);
        {bus_iack, bus_write, bus_read} = kind;
        bus_addr = a;
        bus_wdata = d;
        @(negedge clock);
        {bus_iack, bus_write, bus_read} = 3'h0;
        r = bus_rdata;
    endtask
    task automatic rd(input logic [15:0] a, e);
        access(3'h1, a, 16'h0000);
        compare(r, e);
    endtask
    initial begin
        void'($urandom(19589));
        repeat (10) @(negedge clock);
        reset_n = 1;
        rd(cs, csr(0, 1, 0, 0));
        for (int i = 0; i < 6; i++) begin
            st = i[0];
            w = 16'($urandom);
            access(3'h2, cs, w);
            ie = w[6];
            w = 16'($urandom);
            access(3'h2, cs + BUF_OFFSET, w);
            compare(printer_out, {1'b1, w[7:0]});
            repeat (5) @(negedge clock);
            rd(cs, csr(0, 0, st, st));
            rd(cs + BUF_OFFSET, 16'h0000);
            for (int k = 0; k < 40 && !printer_in.demand; k++) @(negedge clock);
            repeat (4) @(negedge clock);
            rd(cs, csr(0, 1, st, 0));
        end
        access(3'h2, cs, 16'h0040);
        ie = 1;
        fault = 1;
        repeat (4) @(negedge clock);
        rd(cs, csr(1, 0, 0, 0));
        compare(16'(bus_irq), 16'h0001);
        fault = 0;
        repeat (4) @(negedge clock);
        rd(cs, csr(1, 0, 1, 0));
        repeat (4) @(negedge clock);
        rd(cs, csr(0, 1, 1, 0));
        access(3'h4, 16'h0000, 16'h0000);
        compare(r, VECTOR_DEFAULT);
        access(3'h2, cs, 16'h0000);
        ie = 0;
        fault = 1;
        repeat (4) @(negedge clock);
        fault = 0;
        repeat (4) @(negedge clock);
        rd(cs, csr(0, 1, 1, 0));
        access(3'h2, cs, 16'h0040);
        bus_initialise_low = 0;
        repeat (4) @(negedge clock);
        compare(16'(bus_irq), 16'h0000);
        bus_initialise_low = 1;
        ie = 0;
        repeat (3) @(negedge clock);
        rd(cs, csr(0, 1, 1, 0));
        access(3'h2, cs + BUF_OFFSET, 16'h0041);
        bus_initialise_low = 0;
        repeat (3) @(negedge clock);
        bus_initialise_low = 1;
        rd(cs, csr(0, 1, 1, 1));
        rd(16'h0100, 16'h0000);
        conclude();
    end
    initial begin
        #50us;
        mismatches++;
        conclude();
    end
endmodule
